/* design/srrc_defs.svh */
/*
  Register offsets, field positions and reset values of the stop-release and reset control block.
  Assumes it is included by bare name by every design file that needs a number.
*/
`ifndef SRRC_DEFS_SVH
`define SRRC_DEFS_SVH

`define SRRC_ADDR_W 4
`define SRRC_DATA_W 8

`define SRRC_WDM_ADDR 4'h0
`define SRRC_STANDBY_CONTROL_ADDR 4'h1
`define SRRC_MM_ADDR 4'h2
`define SRRC_PWCL_ADDR 4'h3
`define SRRC_PWCH_ADDR 4'h4
`define SRRC_MKL_ADDR 4'h5
`define SRRC_MKH_ADDR 4'h6
`define SRRC_STAT_ADDR 4'h7

`define SRRC_WDM_RESET 8'h00
`define SRRC_WDM_KEEP 8'h9E
`define SRRC_WDM_RUN_BIT 7
`define SRRC_WDM_PRC_BIT 4
`define SRRC_WDM_OVF_LSB 1
`define SRRC_WDM_OVF_MSB 2

`define SRRC_STANDBY_CONTROL_RESET 8'h00
`define SRRC_STANDBY_CONTROL_STOP_BIT 1

`define SRRC_MASK_RESET 16'hFFFF
`define SRRC_PWC_RESET 16'hC0AA
`define SRRC_RESET_VECTOR 16'h0000

`define SRRC_MM_RESET_A 8'h60
`define SRRC_MM_RESET_B 8'h20
`define SRRC_MM_RESET_C 8'h00

`endif

/* design/srrc_pkg.sv */
/*
  Types of the stop-release and reset control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package srrc_pkg;

  typedef enum logic [2:0] {
    SRRC_S_RESET,
    SRRC_S_VECTOR,
    SRRC_S_RUN,
    SRRC_S_STOP,
    SRRC_S_STABLE
  } srrc_state_t;

  typedef enum logic [1:0] {
    SRRC_CTX_NONE,
    SRRC_CTX_WDT,
    SRRC_CTX_NMI
  } srrc_ctx_t;

endpackage : srrc_pkg

/* design/srrc_stab_timer.sv */
/*
  Oscillation stabilisation timer: a free counter with four selectable overflow taps.
  Assumes one clock; clear has priority over count.
*/
`timescale 1ns/1ps
`default_nettype none

module srrc_stab_timer #(
  parameter int CNT_W = 14
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic clear_in,
  input wire logic count_in,
  input wire logic [1:0] sel_in,
  output logic ovf_out
);

  initial begin
    if (CNT_W < 4 || CNT_W > 30) begin
      $error("srrc_stab_timer: CNT_W out of range");
    end
  end

  logic [CNT_W-1:0] cnt_r;
  logic [3:0] tap_hit;

  ////////////////////////////////////////////////////////////////////////////
  // tap k fires when the low CNT_W-3+k bits are all ones
  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_tap
      assign tap_hit[k] = &cnt_r[CNT_W-4+k:0];
    end
  endgenerate

  always_ff @(posedge mclk_in) begin
    if (rst_in || clear_in) begin
      cnt_r <= '0;
    end else if (count_in) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in || clear_in) begin
      ovf_out <= 1'b0;
    end else begin
      ovf_out <= count_in && tap_hit[sel_in];
    end
  end

endmodule : srrc_stab_timer

`default_nettype wire

/* design/srrc_top.sv */
/*
  Stop-mode release, reset sequencing and NMI / watchdog-interrupt arbitration, with the
  control registers loaded on reset.
  Assumes a CPU that reports retired instructions and interrupt returns as one-cycle pulses,
  a synchronous active-low reset pin and a synchronous NMI pin (rising edge valid).
*/
// Functional notes
// - both requests together with watchdog first: one NMI instruction, then watchdog.
// - watchdog mode bits 6, 5, 0 always read zero.
// - priority flag one ranks watchdog above NMI, zero ranks NMI above.
// - stop in watchdog handler, watchdog higher: NMI held until return plus one instruction.
// - stop in watchdog handler, NMI higher: NMI wake branches at once.
// - stop in NMI handler: NMI held, re-entered after return and one instruction.
// - stop outside handlers: NMI wake branches at once.
// - reset during stop restarts oscillator and resets the system.
// - reset pin low holds reset; high releases and starts execution.
// - leaving reset loads the program counter from the vector at address zero.
// - bus wait control resets to three waits, normal fetch.
// - reset puts all ordinary pins in high impedance.
// - reset ending stop keeps stack pointer and RAM contents.
// - reset sets every interrupt mask flag to one.
// - reset clears watchdog mode register.
// - memory expansion control resets to a variant value, 60H, 20H or 00H.
// - stop request halts the oscillator and clears the stabilisation counter.
// - NMI edge restarts oscillator; counter cleared while NMI high; clock on overflow.
`timescale 1ns/1ps
`default_nettype none
`include "srrc_defs.svh"

module srrc_top #(
  parameter logic [7:0] MM_RESET = `SRRC_MM_RESET_B,
  parameter int STAB_W = 14
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic reset_pin_n_in,
  input wire logic nmi_pin_in,
  input wire logic wdt_req_in,
  input wire logic instr_done_in,
  input wire logic return_from_interrupt_in,
  input wire logic [`SRRC_ADDR_W-1:0] reg_addr_in,
  input wire logic [`SRRC_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [`SRRC_DATA_W-1:0] reg_rdata_out,
  output logic osc_enable_out,
  output logic clk_run_out,
  output logic cpu_reset_out,
  output logic pin_hiz_out,
  output logic retain_ram_out,
  output logic vector_load_out,
  output logic [15:0] vector_addr_out,
  output logic nmi_branch_out,
  output logic wdt_branch_out,
  output logic [15:0] bus_wait_control_out,
  output logic [15:0] int_mask_out,
  output logic [7:0] memory_expansion_control_out
);

  initial begin
    if (MM_RESET != `SRRC_MM_RESET_A && MM_RESET != `SRRC_MM_RESET_B &&
        MM_RESET != `SRRC_MM_RESET_C) begin
      $error("srrc_top: MM_RESET is not a variant value");
    end
  end

  srrc_pkg::srrc_state_t state_r, state_nxt;
  srrc_pkg::srrc_ctx_t ctx_r, outer_r;
  logic [7:0] watchdog_mode_r;
  logic [7:0] standby_control_r;
  logic [7:0] mm_r;
  logic [15:0] pwc_r;
  logic [15:0] mask_r;
  logic nmi_d_r;
  logic nmi_pend_r;
  logic wdt_pend_r;
  logic gap_r;
  logic retain_r;
  logic stab_ovf;
  logic nmi_edge;
  logic wdt_nmi_priority_select;
  logic wr_ok;
  logic stop_wr;
  logic take_nmi;
  logic take_wdt;
  logic nmi_ok;
  logic wdt_ok;

  assign nmi_edge = nmi_pin_in && !nmi_d_r;
  assign wdt_nmi_priority_select = watchdog_mode_r[`SRRC_WDM_PRC_BIT];
  assign wr_ok = reg_wr_in && reset_pin_n_in;
  assign stop_wr = wr_ok && reg_addr_in == `SRRC_STANDBY_CONTROL_ADDR &&
                   reg_wdata_in[`SRRC_STANDBY_CONTROL_STOP_BIT] && state_r == srrc_pkg::SRRC_S_RUN;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      srrc_pkg::SRRC_S_RESET: begin
        if (reset_pin_n_in) begin
          state_nxt = srrc_pkg::SRRC_S_VECTOR;
        end
      end
      srrc_pkg::SRRC_S_VECTOR: begin
        state_nxt = srrc_pkg::SRRC_S_RUN;
      end
      srrc_pkg::SRRC_S_RUN: begin
        if (stop_wr) begin
          state_nxt = srrc_pkg::SRRC_S_STOP;
        end
      end
      srrc_pkg::SRRC_S_STOP: begin
        if (nmi_edge) begin
          state_nxt = srrc_pkg::SRRC_S_STABLE;
        end
      end
      srrc_pkg::SRRC_S_STABLE: begin
        if (stab_ovf) begin
          state_nxt = srrc_pkg::SRRC_S_RUN;
        end
      end
      default: begin
        state_nxt = srrc_pkg::SRRC_S_RESET;
      end
    endcase
    if (!reset_pin_n_in) begin
      state_nxt = srrc_pkg::SRRC_S_RESET;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_r <= srrc_pkg::SRRC_S_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // stabilisation counter: cleared in stop and while NMI is active
  srrc_stab_timer #(
    .CNT_W(STAB_W)
  ) u_stab (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .clear_in(state_r != srrc_pkg::SRRC_S_STABLE || nmi_pin_in),
    .count_in(state_r == srrc_pkg::SRRC_S_STABLE && !nmi_pin_in),
    .sel_in(watchdog_mode_r[`SRRC_WDM_OVF_MSB:`SRRC_WDM_OVF_LSB]),
    .ovf_out(stab_ovf)
  );

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      osc_enable_out <= 1'b1;
      clk_run_out <= 1'b0;
      cpu_reset_out <= 1'b1;
      pin_hiz_out <= 1'b1;
      vector_load_out <= 1'b0;
      vector_addr_out <= `SRRC_RESET_VECTOR;
    end else begin
      osc_enable_out <= state_nxt != srrc_pkg::SRRC_S_STOP;
      clk_run_out <= state_nxt == srrc_pkg::SRRC_S_RUN || state_nxt == srrc_pkg::SRRC_S_VECTOR;
      cpu_reset_out <= state_nxt == srrc_pkg::SRRC_S_RESET;
      pin_hiz_out <= state_nxt == srrc_pkg::SRRC_S_RESET;
      vector_load_out <= state_nxt == srrc_pkg::SRRC_S_VECTOR;
      vector_addr_out <= `SRRC_RESET_VECTOR;
    end
  end

  // ram and stack keep their values when reset ends a stop period
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      retain_r <= 1'b0;
    end else if (!reset_pin_n_in && (state_r == srrc_pkg::SRRC_S_STOP ||
                                     state_r == srrc_pkg::SRRC_S_STABLE)) begin
      retain_r <= 1'b1;
    end else if (state_r == srrc_pkg::SRRC_S_RUN) begin
      retain_r <= 1'b0;
    end
  end
  assign retain_ram_out = retain_r;

  ////////////////////////////////////////////////////////////////////////////
  // NMI / watchdog arbitration
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      nmi_d_r <= 1'b0;
    end else begin
      nmi_d_r <= nmi_pin_in;
    end
  end

  // NMI allowed unless already in NMI, or in watchdog handler with watchdog higher
  assign nmi_ok = nmi_pend_r && ctx_r != srrc_pkg::SRRC_CTX_NMI &&
                  !(ctx_r == srrc_pkg::SRRC_CTX_WDT && wdt_nmi_priority_select);
  assign wdt_ok = wdt_pend_r && (ctx_r == srrc_pkg::SRRC_CTX_NONE ||
                  (ctx_r == srrc_pkg::SRRC_CTX_NMI && wdt_nmi_priority_select));
  // NMI checked first: on a tie it always gets its first instruction in
  assign take_nmi = state_r == srrc_pkg::SRRC_S_RUN && !gap_r && nmi_ok;
  assign take_wdt = state_r == srrc_pkg::SRRC_S_RUN && !gap_r && !nmi_ok && wdt_ok;

  always_ff @(posedge mclk_in) begin
    if (rst_in || !reset_pin_n_in) begin
      nmi_pend_r <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend_r <= 1'b1;
    end else if (take_nmi) begin
      nmi_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in || !reset_pin_n_in) begin
      wdt_pend_r <= 1'b0;
    end else if (wdt_req_in) begin
      wdt_pend_r <= 1'b1;
    end else if (take_wdt) begin
      wdt_pend_r <= 1'b0;
    end
  end

  // one instruction must retire after each branch or return before the next branch
  always_ff @(posedge mclk_in) begin
    if (rst_in || !reset_pin_n_in) begin
      gap_r <= 1'b0;
    end else if (take_nmi || take_wdt || return_from_interrupt_in) begin
      gap_r <= 1'b1;
    end else if (instr_done_in) begin
      gap_r <= 1'b0;
    end
  end

  // two-deep handler context
  always_ff @(posedge mclk_in) begin
    if (rst_in || !reset_pin_n_in) begin
      ctx_r <= srrc_pkg::SRRC_CTX_NONE;
      outer_r <= srrc_pkg::SRRC_CTX_NONE;
    end else if (take_nmi) begin
      outer_r <= ctx_r;
      ctx_r <= srrc_pkg::SRRC_CTX_NMI;
    end else if (take_wdt) begin
      outer_r <= ctx_r;
      ctx_r <= srrc_pkg::SRRC_CTX_WDT;
    end else if (return_from_interrupt_in && state_r == srrc_pkg::SRRC_S_RUN) begin
      ctx_r <= outer_r;
      outer_r <= srrc_pkg::SRRC_CTX_NONE;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      nmi_branch_out <= 1'b0;
      wdt_branch_out <= 1'b0;
    end else begin
      nmi_branch_out <= take_nmi;
      wdt_branch_out <= take_wdt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge mclk_in) begin
    if (rst_in || !reset_pin_n_in) begin
      watchdog_mode_r <= `SRRC_WDM_RESET;
    end else if (wr_ok && reg_addr_in == `SRRC_WDM_ADDR) begin
      // run bit sticks once set
      watchdog_mode_r <= (reg_wdata_in & `SRRC_WDM_KEEP) |
                         (watchdog_mode_r & (8'h01 << `SRRC_WDM_RUN_BIT));
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in || !reset_pin_n_in) begin
      standby_control_r <= `SRRC_STANDBY_CONTROL_RESET;
    end else if (state_r == srrc_pkg::SRRC_S_STABLE && stab_ovf) begin
      standby_control_r[`SRRC_STANDBY_CONTROL_STOP_BIT] <= 1'b0;
    end else if (wr_ok && reg_addr_in == `SRRC_STANDBY_CONTROL_ADDR) begin
      standby_control_r <= reg_wdata_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in || !reset_pin_n_in) begin
      mm_r <= MM_RESET;
    end else if (wr_ok && reg_addr_in == `SRRC_MM_ADDR) begin
      mm_r <= reg_wdata_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in || !reset_pin_n_in) begin
      pwc_r <= `SRRC_PWC_RESET;
    end else if (wr_ok && reg_addr_in == `SRRC_PWCL_ADDR) begin
      pwc_r[7:0] <= reg_wdata_in;
    end else if (wr_ok && reg_addr_in == `SRRC_PWCH_ADDR) begin
      pwc_r[15:8] <= reg_wdata_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in || !reset_pin_n_in) begin
      mask_r <= `SRRC_MASK_RESET;
    end else if (wr_ok && reg_addr_in == `SRRC_MKL_ADDR) begin
      mask_r[7:0] <= reg_wdata_in;
    end else if (wr_ok && reg_addr_in == `SRRC_MKH_ADDR) begin
      mask_r[15:8] <= reg_wdata_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      bus_wait_control_out <= `SRRC_PWC_RESET;
      int_mask_out <= `SRRC_MASK_RESET;
      memory_expansion_control_out <= MM_RESET;
    end else begin
      bus_wait_control_out <= pwc_r;
      int_mask_out <= mask_r;
      memory_expansion_control_out <= mm_r;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in || !reg_rd_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      case (reg_addr_in)
        `SRRC_WDM_ADDR: reg_rdata_out <= watchdog_mode_r;
        `SRRC_STANDBY_CONTROL_ADDR: reg_rdata_out <= standby_control_r;
        `SRRC_MM_ADDR: reg_rdata_out <= mm_r;
        `SRRC_PWCL_ADDR: reg_rdata_out <= pwc_r[7:0];
        `SRRC_PWCH_ADDR: reg_rdata_out <= pwc_r[15:8];
        `SRRC_MKL_ADDR: reg_rdata_out <= mask_r[7:0];
        `SRRC_MKH_ADDR: reg_rdata_out <= mask_r[15:8];
        `SRRC_STAT_ADDR: reg_rdata_out <= {2'h0, retain_r, ctx_r, gap_r, wdt_pend_r, nmi_pend_r};
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  a_tie_one_instr: assert property (
    (state_r == srrc_pkg::SRRC_S_RUN && ctx_r == srrc_pkg::SRRC_CTX_NMI && wdt_nmi_priority_select && wdt_pend_r && gap_r &&
     instr_done_in && !return_from_interrupt_in && !reg_wr_in && reset_pin_n_in) |=> take_wdt)
    else $error("watchdog not entered after one NMI instruction");
  a_wdm_zero_bits: assert property (
    (watchdog_mode_r & ~`SRRC_WDM_KEEP) == 8'h00)
    else $error("watchdog mode fixed bits not zero");
  a_prio_rank: assert property (
    (state_r == srrc_pkg::SRRC_S_RUN && ctx_r == srrc_pkg::SRRC_CTX_NMI && wdt_pend_r && !gap_r)
    |-> (take_wdt == wdt_nmi_priority_select))
    else $error("watchdog priority flag ignored");
  a_nmi_held: assert property (
    (ctx_r == srrc_pkg::SRRC_CTX_NMI || (ctx_r == srrc_pkg::SRRC_CTX_WDT && wdt_nmi_priority_select)) |-> !take_nmi)
    else $error("NMI taken while it must be held");
  a_stop_osc_off: assert property (
    (stop_wr && reset_pin_n_in) |=> (!osc_enable_out && !clk_run_out) [*2])
    else $error("oscillator not stopped");
  a_stable_hold: assert property (
    (state_r == srrc_pkg::SRRC_S_STABLE && nmi_pin_in && reset_pin_n_in) |=>
    (state_r == srrc_pkg::SRRC_S_STABLE && !clk_run_out))
    else $error("clock resumed while NMI active");
  a_reset_stop: assert property (
    (state_r == srrc_pkg::SRRC_S_STOP && !reset_pin_n_in) |=> (osc_enable_out && cpu_reset_out))
    else $error("reset did not restart oscillator");
  a_reset_hiz: assert property (
    !reset_pin_n_in |=> (pin_hiz_out && cpu_reset_out && !clk_run_out))
    else $error("pins not released to high impedance");
  a_vector_load: assert property (
    (state_r == srrc_pkg::SRRC_S_RESET && reset_pin_n_in) |=>
    (vector_load_out && vector_addr_out == `SRRC_RESET_VECTOR) ##1 !vector_load_out)
    else $error("reset vector not loaded");
  a_reset_values: assert property (
    !reset_pin_n_in |=> (mask_r == `SRRC_MASK_RESET && watchdog_mode_r == `SRRC_WDM_RESET &&
                         pwc_r == `SRRC_PWC_RESET && mm_r == MM_RESET) ##1
                        (int_mask_out == `SRRC_MASK_RESET))
    else $error("reset values not loaded");
  a_retain_ram: assert property (
    (state_r == srrc_pkg::SRRC_S_STOP && !reset_pin_n_in) |=> retain_ram_out [*2])
    else $error("retention flag lost");

  c_stop_wake: cover property (state_r == srrc_pkg::SRRC_S_STABLE ##1 state_r == srrc_pkg::SRRC_S_RUN);
  c_tie: cover property (take_nmi && wdt_pend_r && wdt_nmi_priority_select ##[1:20] take_wdt);
  c_held_nmi: cover property (ctx_r == srrc_pkg::SRRC_CTX_NMI && nmi_pend_r ##[1:40] take_nmi);
  c_vector: cover property (vector_load_out && retain_ram_out);

endmodule : srrc_top

`default_nettype wire

/* testbench/srrc_ext_src.sv */
/*
  Model of the board-side sources: a reset supervisor driving the active-low reset pin and
  an NMI source driving the NMI pin.
  Assumes one clock shared with the block; requests are one-cycle pulses from the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module srrc_ext_src #(
  parameter int RESET_HOLD = 8,
  parameter int NMI_HOLD = 4
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic reset_req_in,
  input wire logic nmi_req_in,
  output logic reset_pin_n_out,
  output logic nmi_pin_out
);
  int rst_cnt_r;
  int nmi_cnt_r;

  ////////////////////////////////////////////////////////////////////////////////
  // reset pin held low long enough for the oscillator to settle
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rst_cnt_r <= 0;
    end else if (reset_req_in) begin
      rst_cnt_r <= RESET_HOLD;
    end else if (rst_cnt_r != 0) begin
      rst_cnt_r <= rst_cnt_r - 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // nmi pulse, idles at the inactive level
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      nmi_cnt_r <= 0;
    end else if (nmi_req_in) begin
      nmi_cnt_r <= NMI_HOLD;
    end else if (nmi_cnt_r != 0) begin
      nmi_cnt_r <= nmi_cnt_r - 1;
    end
  end

  assign reset_pin_n_out = (rst_cnt_r == 0);
  assign nmi_pin_out = (nmi_cnt_r != 0);
endmodule : srrc_ext_src

`default_nettype wire

/* testbench/test_stop_release_reset_control.sv */
/*
  Self-checking bench for the stop-release and reset control block.
  Assumes the block under test and the board-source model; outputs are sampled at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
`include "srrc_defs.svh"

module test_stop_release_reset_control;
  logic mclk_in = 0, rst_in, reset_pin_n, nmi_pin, reset_req, nmi_req;
  logic wdt_req, instr_done, return_from_interrupt, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, mm_out, rd;
  logic osc_en, clk_run, cpu_rst, pin_hiz, retain, vec_load, nmi_br, wdt_br;
  logic [15:0] vec_addr, pwc_out, mask_out;
  int fails = 0, check_count = 0;
  bit found;

  always #50 mclk_in = ~mclk_in;

  srrc_ext_src #(.RESET_HOLD(8), .NMI_HOLD(4)) src (.mclk_in(mclk_in), .rst_in(rst_in),
    .reset_req_in(reset_req), .nmi_req_in(nmi_req), .reset_pin_n_out(reset_pin_n), .nmi_pin_out(nmi_pin));

  srrc_top #(.MM_RESET(8'h20), .STAB_W(4)) DUT (.mclk_in(mclk_in), .rst_in(rst_in),
    .reset_pin_n_in(reset_pin_n), .nmi_pin_in(nmi_pin), .wdt_req_in(wdt_req), .instr_done_in(instr_done),
    .return_from_interrupt_in(return_from_interrupt), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .osc_enable_out(osc_en), .clk_run_out(clk_run), .cpu_reset_out(cpu_rst),
    .pin_hiz_out(pin_hiz), .retain_ram_out(retain), .vector_load_out(vec_load), .vector_addr_out(vec_addr),
    .nmi_branch_out(nmi_br), .wdt_branch_out(wdt_br), .bus_wait_control_out(pwc_out),
    .int_mask_out(mask_out), .memory_expansion_control_out(mm_out));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      fails++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  function automatic logic sig(input int s);
    case (s)
      0: return nmi_br;
      1: return wdt_br;
      2: return clk_run;
      default: return vec_load;
    endcase
  endfunction : sig

  // waits up to n falling edges for a selected output to be high
  task automatic wait_for(input int s, input int n, output bit seen);
    seen = 0;
    for (int i = 0; i < n && !seen; i++) begin
      @(negedge mclk_in);
      seen = (sig(s) === 1'b1);
    end
  endtask : wait_for

  ////////////////////////////////////////////////////////////////////////////////
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk_in);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk_in);
    reg_rd <= 1'b0;
    @(negedge mclk_in);
    d = reg_rdata;
  endtask : reg_read

  task automatic pulse_instr;
    @(posedge mclk_in);
    instr_done <= 1'b1;
    @(posedge mclk_in);
    instr_done <= 1'b0;
  endtask : pulse_instr

  task automatic pulse_return_from_interrupt;
    @(posedge mclk_in);
    return_from_interrupt <= 1'b1;
    @(posedge mclk_in);
    return_from_interrupt <= 1'b0;
  endtask : pulse_return_from_interrupt

  // nmi pin rises in the same cycle as the optional watchdog request
  task automatic fire_nmi(input bit with_wdt);
    @(posedge mclk_in);
    nmi_req <= 1'b1;
    @(posedge mclk_in);
    nmi_req <= 1'b0;
    wdt_req <= with_wdt;
    @(posedge mclk_in);
    wdt_req <= 1'b0;
  endtask : fire_nmi

  task automatic pin_reset;
    @(posedge mclk_in);
    reset_req <= 1'b1;
    @(posedge mclk_in);
    reset_req <= 1'b0;
    repeat (3) @(negedge mclk_in);
  endtask : pin_reset

  ////////////////////////////////////////////////////////////////////////////////
  task automatic do_reset;
    pin_reset();
    chk(cpu_rst === 1'b1 && pin_hiz === 1'b1, "reset pin low not holding reset");
    wait_for(3, 20, found);
    chk(found, "no vector load after reset release");
    chk(vec_addr === 16'h0000 && cpu_rst === 1'b0, "bad vector address");
  endtask : do_reset

  task automatic reg_case;
    do_reset();
    chk(pwc_out === 16'hC0AA, "wait control reset");
    chk(mask_out === 16'hFFFF, "mask reset");
    chk(mm_out === 8'h20, "expansion control reset");
    reg_read(`SRRC_WDM_ADDR, rd);
    chk(rd === 8'h00, "watchdog mode reset");
    reg_read(`SRRC_PWCL_ADDR, rd);
    chk(rd === 8'hAA, "wait control low byte");
    reg_read(`SRRC_MKH_ADDR, rd);
    chk(rd === 8'hFF, "mask high byte");
    reg_read(4'h8, rd);
    chk(rd === 8'h00, "unmapped read");
    reg_write(`SRRC_WDM_ADDR, 8'hF7);
    reg_read(`SRRC_WDM_ADDR, rd);
    chk(rd === 8'h96, "fixed zero bits");
  endtask : reg_case

  task automatic tie_case(input bit flag);
    do_reset();
    reg_write(`SRRC_WDM_ADDR, {3'b000, flag, 4'h0});
    fire_nmi(1'b1);
    wait_for(0, 6, found);
    chk(found, "tie: nmi branch missing");
    wait_for(1, 3, found);
    chk(!found, "tie: watchdog branch before one instruction");
    pulse_instr();
    wait_for(1, 5, found);
    chk(found === flag, "tie: watchdog preemption wrong for priority");
    if (!flag) begin
      pulse_return_from_interrupt();
      pulse_instr();
      wait_for(1, 5, found);
      chk(found, "tie: watchdog not taken after nmi return");
    end
  endtask : tie_case

  // ctx: 0 outside handlers, 1 watchdog handler, 2 nmi handler
  task automatic stop_case(input int ctx, input bit flag, input bit immediate);
    do_reset();
    reg_write(`SRRC_WDM_ADDR, {3'b000, flag, 4'h0});
    if (ctx == 1) begin
      @(posedge mclk_in);
      wdt_req <= 1'b1;
      @(posedge mclk_in);
      wdt_req <= 1'b0;
      wait_for(1, 5, found);
      chk(found, "watchdog branch missing");
    end else if (ctx == 2) begin
      fire_nmi(1'b0);
      wait_for(0, 5, found);
      chk(found, "nmi branch missing");
    end
    pulse_instr();
    repeat (5) @(posedge mclk_in);
    reg_write(`SRRC_STANDBY_CONTROL_ADDR, 8'h02);
    repeat (2) @(negedge mclk_in);
    chk(osc_en === 1'b0 && clk_run === 1'b0, "stop did not halt oscillator");
    fire_nmi(1'b0);
    @(negedge mclk_in);
    chk(osc_en === 1'b1 && clk_run === 1'b0, "nmi wake: oscillator or early clock");
    if (immediate) begin
      wait_for(0, 40, found);
      chk(found, "wake did not branch to nmi");
      pulse_return_from_interrupt();
      reg_read(`SRRC_STAT_ADDR, rd);
      chk(rd === ((ctx == 1) ? 8'h0C : 8'h04), "nmi return did not resume interrupted context");
    end else begin
      wait_for(2, 40, found);
      chk(found, "clock did not resume");
      pulse_instr();
      wait_for(0, 4, found);
      chk(!found, "nmi not held pending");
      pulse_return_from_interrupt();
      pulse_instr();
      wait_for(0, 6, found);
      chk(found, "held nmi not taken after return");
    end
  endtask : stop_case

  task automatic reset_stop_case;
    do_reset();
    reg_write(`SRRC_STANDBY_CONTROL_ADDR, 8'h02);
    repeat (2) @(negedge mclk_in);
    chk(osc_en === 1'b0, "stop not entered");
    pin_reset();
    chk(osc_en === 1'b1 && cpu_rst === 1'b1, "reset in stop");
    chk(retain === 1'b1 && pin_hiz === 1'b1, "ram not kept or pins driven");
    wait_for(3, 20, found);
    chk(found, "no start after reset in stop");
  endtask : reset_stop_case

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_in, reset_req, nmi_req, wdt_req, instr_done, return_from_interrupt, reg_wr, reg_rd} = 8'h80;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    reg_case();
    tie_case(1'b1);
    tie_case(1'b0);
    stop_case(0, 1'b0, 1'b1);
    stop_case(1, 1'b1, 1'b0);
    stop_case(1, 1'b0, 1'b1);
    stop_case(2, 1'b1, 1'b0);
    reset_stop_case();
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge mclk_in);
    fails++;
    print_verdict();
  end
endmodule : test_stop_release_reset_control

`default_nettype wire
